// ==== fsi_regs.svh ====
// constants of the secure-id / status command block
// Notes on behaviour
// - single-line id read: opcode, two address bytes, one dummy byte, then data.
// - four-line id read: opcode, two address bytes, three dummy bytes, then data.
// - id data leaves on falling sck from the given address, streaming until select rises.
// - id program: opcode, two address bytes, 1 to 256 whole bytes; partial byte dropped.
// - id program to factory, protected or out-of-range address is ignored.
// - over 256 bytes keeps the last 256; overflow wraps inside the same page.
// - lockout opcode permanently freezes the id area; self-timed, shown through busy.
// - status/config read follows the opcode; four-line adds one dummy; repeats until select rises.
// - status read is accepted while busy too, but not while asleep.
// - register write: first data byte loads status, optional second loads config.
// - write-latch-set opcode sets the write-enable latch.
// - write-latch-clear clears the latch; ignored during an internal write.
// - lockdown sets the locked flag, freezes protect bits until hardware reset.
// - deep sleep ignored while busy; asleep, only the release opcode is honoured.
// - deep sleep reached at most 3 us after select rises.
// - release leaves deep sleep, ready at most 10 us after select rises.
// - release plus three dummy bytes streams the device id until select rises.
`ifndef FSI_REGS_SVH
`define FSI_REGS_SVH
`define FSI_OP_ID_READ    8'h88
`define FSI_OP_ID_PROG    8'ha5
`define FSI_OP_ID_LOCK    8'h85
`define FSI_OP_RD_STATUS  8'h05
`define FSI_OP_RD_CONFIG  8'h35
`define FSI_OP_WR_REGS    8'h01
`define FSI_OP_WL_SET     8'h06
`define FSI_OP_WL_CLR     8'h04
`define FSI_OP_LOCKDOWN   8'h8d
`define FSI_OP_SLEEP      8'hb9
`define FSI_OP_WAKE       8'hab
`define FSI_OP_NONE       8'hff
`define FSI_DUMMY_ID_X1   2'd1
`define FSI_DUMMY_ID_X4   2'd3
`define FSI_DUMMY_RD_X4   2'd1
`define FSI_DUMMY_WAKE    2'd3
`define FSI_ADDR_BYTES    2'd2
`define FSI_ID_FACTORY_END 11'h00f
`define FSI_ID_FIRST_USER 16'h0010
`define FSI_ID_LAST       16'h07ff
`define FSI_CF_LOCKED     3
`define FSI_CF_WMASK      8'hf7
`define FSI_CONFIG_RST    8'h00
`define FSI_BP_RST        4'h0
`define FSI_A_CTRL        12'h000
`define FSI_A_STATUS      12'h004
`define FSI_A_CONFIG      12'h008
`define FSI_A_STATE       12'h00c
`define FSI_CTRL_QUAD     0
`define FSI_CLK_NS        8
`define FSI_T_ID_PROG_NS  1500000
`define FSI_T_CONFIG_NS   25000000
`define FSI_T_SLEEP_NS    3000
`define FSI_T_EXIT_NS     10000
`define FSI_SLEEP_CYC     16'((`FSI_T_SLEEP_NS) / (`FSI_CLK_NS))
`define FSI_EXIT_CYC      16'((`FSI_T_EXIT_NS) / (`FSI_CLK_NS))
`endif

// ==== fsi_pkg.sv ====
// types shared by the secure-id / status command block
package fsi_pkg;
  typedef enum {st_cmd, st_addr, st_dummy, st_din, st_dout, st_skip} fsi_state_t;
  typedef logic [7:0]  fsi_byte_t;
  typedef logic [31:0] fsi_word_t;
endpackage

// ==== fsi_flash_cmd.sv ====
// serial flash command decoder: secure id, status/config, latch, lockdown, deep sleep
`timescale 1ns/1ps
`include "fsi_regs.svh"
module fsi_flash_cmd #(
  parameter int unsigned  ID_PROG_CYC = `FSI_T_ID_PROG_NS / `FSI_CLK_NS,
  parameter int unsigned  CONFIG_CYC  = `FSI_T_CONFIG_NS / `FSI_CLK_NS,
  parameter logic [127:0] FACTORY_ID  = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0, // arbitrary
  parameter logic [7:0]   DEVICE_ID   = 8'h5a                                   // arbitrary
) (
  input  logic              clock,
  input  logic              rst_n,
  input  logic              psel,
  input  logic              penable,
  input  logic              pwrite,
  input  logic [11:0]       paddr,
  input  fsi_pkg::fsi_word_t pwdata,
  output fsi_pkg::fsi_word_t prdata,
  output logic              pready,
  output logic              pslverr,
  input  logic              sck,
  input  logic              cs_n,
  input  logic [3:0]        io_in,
  output logic [3:0]        io_out,
  output logic [3:0]        io_oe
);
  import fsi_pkg::*;

  logic [5:0]  pin_s1_q;
  logic [5:0]  pin_s2_q;
  logic        sck_prev_q;
  logic        cs_prev_q;
  logic        sck_rise;
  logic        sck_fall;
  logic        cs_rise;
  logic        cs_fall;
  logic        frame;
  logic [3:0]  pin_io;
  logic        quad_q;
  logic [3:0]  step;
  logic [3:0]  bit_q;
  fsi_byte_t   sh_q;
  fsi_byte_t   sh_d;
  logic        byte_done;
  fsi_state_t  st_q;
  fsi_byte_t   op_q;
  logic [1:0]  cnt_q;
  logic [1:0]  nwr_q;
  fsi_byte_t   new_sr_q;
  fsi_byte_t   new_cr_q;
  logic [15:0] addr_q;
  logic        start_ok_q;
  fsi_byte_t   pb_q [256];
  logic [255:0] pv_q;
  fsi_byte_t   mem_q [2048];
  logic        wel_q;
  logic [3:0]  bp_q;
  fsi_byte_t   cfg_q;
  logic        idlock_q;
  logic [31:0] busy_cnt_q;
  logic        busy;
  logic        sleep_q;
  logic [15:0] enter_cnt_q;
  logic [15:0] exit_cnt_q;
  logic        dormant;
  fsi_byte_t   status_w;
  logic        prog_go;
  fsi_byte_t   src;
  fsi_byte_t   cur;
  fsi_byte_t   osh_q;
  logic [3:0]  ocnt_q;
  logic [3:0]  ocnt_n;
  logic [3:0]  io_out_q;
  logic [3:0]  io_oe_q;
  fsi_word_t   prdata_q;
  fsi_word_t   rd_w;
  logic        mapped;
  logic        pready_q;
  logic        pslverr_q;

  // which opcodes the decoder takes in the present device state
  function automatic logic cmd_ok(input fsi_byte_t op, input logic dorm, input logic bsy);
    if (dorm) begin
      cmd_ok = (op == `FSI_OP_WAKE);
    end else if (bsy) begin
      cmd_ok = (op == `FSI_OP_RD_STATUS) || (op == `FSI_OP_RD_CONFIG);
    end else begin
      cmd_ok = 1'b1;
    end
  endfunction

  // two-stage synchroniser for the pins; sck idles low, select idles high
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_s1_q <= 6'h10;
      pin_s2_q <= 6'h10;
    end else begin
      pin_s1_q <= {sck, cs_n, io_in};
      pin_s2_q <= pin_s1_q;
    end
  end

  // edge finders look at the second stage only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end else begin
      sck_prev_q <= pin_s2_q[5];
      cs_prev_q  <= pin_s2_q[4];
    end
  end

  assign sck_rise = pin_s2_q[5] & ~sck_prev_q;
  assign sck_fall = ~pin_s2_q[5] & sck_prev_q;
  assign cs_rise  = pin_s2_q[4] & ~cs_prev_q;
  assign cs_fall  = ~pin_s2_q[4] & cs_prev_q;
  assign frame    = ~pin_s2_q[4];
  assign pin_io   = pin_s2_q[3:0];
  assign step     = quad_q ? 4'd4 : 4'd1;

  // input shifter: one lane or four lanes per rising sck
  always_comb begin
    sh_d      = quad_q ? {sh_q[3:0], pin_io} : {sh_q[6:0], pin_io[0]};
    byte_done = sck_rise && frame && ((bit_q + step) == 4'd8);
  end

  // a partial byte left at select rise is simply dropped with the count
  always_ff @(posedge clock) begin
    if (!rst_n || !frame) begin
      bit_q <= 4'h0;
      sh_q  <= 8'h00;
    end else if (sck_rise) begin
      bit_q <= byte_done ? 4'h0 : bit_q + step;
      sh_q  <= sh_d;
    end
  end

  // command sequencer, restarted by every select fall
  always_ff @(posedge clock) begin
    if (!rst_n || !frame) begin
      st_q     <= st_cmd;
      op_q     <= `FSI_OP_NONE;
      cnt_q    <= 2'd0;
      nwr_q    <= 2'd0;
      new_sr_q <= 8'h00;
      new_cr_q <= 8'h00;
    end else if (byte_done) begin
      case (st_q)
        st_cmd: begin
          op_q <= cmd_ok(sh_d, dormant, busy) ? sh_d : `FSI_OP_NONE;
          st_q <= st_skip;
          if (cmd_ok(sh_d, dormant, busy)) begin
            case (sh_d)
              `FSI_OP_ID_READ, `FSI_OP_ID_PROG: begin
                st_q  <= st_addr;
                cnt_q <= `FSI_ADDR_BYTES;
              end
              `FSI_OP_RD_STATUS, `FSI_OP_RD_CONFIG: begin
                st_q  <= quad_q ? st_dummy : st_dout;
                cnt_q <= `FSI_DUMMY_RD_X4;
              end
              `FSI_OP_WR_REGS: begin
                st_q <= st_din;
              end
              `FSI_OP_WAKE: begin
                st_q  <= st_dummy;
                cnt_q <= `FSI_DUMMY_WAKE;
              end
              default: begin
                st_q <= st_skip;
              end
            endcase
          end
        end
        st_addr: begin
          cnt_q <= cnt_q - 2'd1;
          if (cnt_q == 2'd1) begin
            if (op_q == `FSI_OP_ID_READ) begin
              st_q  <= st_dummy;
              cnt_q <= quad_q ? `FSI_DUMMY_ID_X4 : `FSI_DUMMY_ID_X1;
            end else begin
              st_q <= st_din;
            end
          end
        end
        st_dummy: begin
          cnt_q <= cnt_q - 2'd1;
          if (cnt_q == 2'd1) begin
            st_q <= st_dout;
          end
        end
        st_din: begin
          if (op_q == `FSI_OP_WR_REGS && nwr_q != 2'd2) begin
            nwr_q <= nwr_q + 2'd1;
            if (nwr_q == 2'd0) begin
              new_sr_q <= sh_d;
            end else begin
              new_cr_q <= sh_d;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // address: loaded by the address bytes, walked by reads and program data
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      addr_q     <= 16'h0000;
      start_ok_q <= 1'b0;
    end else if (byte_done && st_q == st_addr) begin
      addr_q     <= {addr_q[7:0], sh_d};
      start_ok_q <= ({addr_q[7:0], sh_d} >= `FSI_ID_FIRST_USER) &&
                    ({addr_q[7:0], sh_d} <= `FSI_ID_LAST);
    end else if (byte_done && st_q == st_din && op_q == `FSI_OP_ID_PROG) begin
      addr_q[7:0] <= addr_q[7:0] + 8'h01;
    end else if (sck_fall && st_q == st_dout && ocnt_q == 4'h0 && op_q == `FSI_OP_ID_READ) begin
      addr_q <= {5'h00, addr_q[10:0] + 11'h001};
    end
  end

  // page buffer: later bytes overwrite earlier ones, so the last 256 win
  always_ff @(posedge clock) begin
    if (byte_done && st_q == st_din && op_q == `FSI_OP_ID_PROG) begin
      pb_q[addr_q[7:0]] <= sh_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || cs_fall) begin
      pv_q <= '0;
    end else if (byte_done && st_q == st_din && op_q == `FSI_OP_ID_PROG) begin
      pv_q[addr_q[7:0]] <= 1'b1;
    end
  end

  assign prog_go = cs_rise && op_q == `FSI_OP_ID_PROG && wel_q && start_ok_q && !idlock_q && (|pv_q);

  // id array: bits only fall, factory bytes are never touched by a program
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < 2048; i++) begin
        mem_q[i] <= (i < 16) ? FACTORY_ID[8*(15-(i%16)) +: 8] : 8'hff;
      end
    end else if (prog_go) begin
      for (int i = 0; i < 256; i++) begin
        if (pv_q[i] && {addr_q[10:8], 8'(i)} > `FSI_ID_FACTORY_END) begin
          mem_q[{addr_q[10:8], 8'(i)}] <= mem_q[{addr_q[10:8], 8'(i)}] & pb_q[i];
        end
      end
    end
  end

  assign busy     = (busy_cnt_q != 32'h0);
  assign status_w = {1'b0, idlock_q, bp_q, wel_q, busy};
  assign dormant  = sleep_q || (enter_cnt_q != 16'h0) || (exit_cnt_q != 16'h0);

  // end-of-frame actions; every latch-gated command consumes the latch, except a register write with no data byte
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wel_q      <= 1'b0;
      bp_q       <= `FSI_BP_RST;
      cfg_q      <= `FSI_CONFIG_RST;
      idlock_q   <= 1'b0;
      busy_cnt_q <= 32'h0;
    end else begin
      if (busy) begin
        busy_cnt_q <= busy_cnt_q - 32'h1;
      end
      if (cs_rise) begin
        case (op_q)
          `FSI_OP_WL_SET: begin
            wel_q <= 1'b1;
          end
          `FSI_OP_WL_CLR: begin
            if (!busy) begin
              wel_q <= 1'b0;
            end
          end
          `FSI_OP_ID_LOCK: begin
            if (wel_q) begin
              idlock_q   <= 1'b1;
              wel_q      <= 1'b0;
              busy_cnt_q <= ID_PROG_CYC;
            end
          end
          `FSI_OP_LOCKDOWN: begin
            if (wel_q) begin
              cfg_q[`FSI_CF_LOCKED] <= 1'b1;
              wel_q              <= 1'b0;
            end
          end
          `FSI_OP_WR_REGS: begin
            if (wel_q && nwr_q != 2'd0) begin
              if (!cfg_q[`FSI_CF_LOCKED]) begin
                bp_q <= new_sr_q[5:2];
              end
              if (nwr_q == 2'd2) begin
                cfg_q <= (cfg_q & ~`FSI_CF_WMASK) | (new_cr_q & `FSI_CF_WMASK);
              end
              wel_q      <= 1'b0;
              busy_cnt_q <= CONFIG_CYC;
            end
          end
          `FSI_OP_ID_PROG: begin
            wel_q <= 1'b0;
            if (prog_go) begin
              busy_cnt_q <= ID_PROG_CYC;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // deep sleep entry and exit timers; a release cancels a pending entry
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sleep_q     <= 1'b0;
      enter_cnt_q <= 16'h0;
      exit_cnt_q  <= 16'h0;
    end else begin
      if (cs_rise && op_q == `FSI_OP_WAKE) begin
        exit_cnt_q  <= `FSI_EXIT_CYC;
        enter_cnt_q <= 16'h0;
      end else begin
        if (cs_rise && op_q == `FSI_OP_SLEEP) begin
          enter_cnt_q <= `FSI_SLEEP_CYC;
        end else if (enter_cnt_q != 16'h0) begin
          enter_cnt_q <= enter_cnt_q - 16'h1;
          if (enter_cnt_q == 16'h1) begin
            sleep_q <= 1'b1;
          end
        end
        if (exit_cnt_q != 16'h0) begin
          exit_cnt_q <= exit_cnt_q - 16'h1;
          if (exit_cnt_q == 16'h1) begin
            sleep_q <= 1'b0;
          end
        end
      end
    end
  end

  // byte offered to the output shifter when a new byte starts
  always_comb begin
    case (op_q)
      `FSI_OP_RD_STATUS: src = status_w;
      `FSI_OP_RD_CONFIG: src = cfg_q;
      `FSI_OP_WAKE:      src = DEVICE_ID;
      default:           src = mem_q[addr_q[10:0]];
    endcase
    cur    = (ocnt_q == 4'h0) ? src : osh_q;
    ocnt_n = ((ocnt_q + step) == 4'd8) ? 4'h0 : ocnt_q + step;
  end

  // output lanes change on falling sck only; enables drop once select is seen high
  always_ff @(posedge clock) begin
    if (!rst_n || !frame) begin
      osh_q    <= 8'h00;
      ocnt_q   <= 4'h0;
      io_out_q <= 4'h0;
      io_oe_q  <= 4'h0;
    end else if (sck_fall && st_q == st_dout) begin
      io_out_q <= quad_q ? cur[7:4] : {2'b00, cur[7], 1'b0};
      io_oe_q  <= quad_q ? 4'hf : 4'h2;
      osh_q    <= quad_q ? {cur[3:0], 4'h0} : {cur[6:0], 1'b0};
      ocnt_q   <= ocnt_n;
    end
  end

  assign io_out = io_out_q;
  assign io_oe  = io_oe_q;

  // register read mux; anything else is an error on the bus
  always_comb begin
    mapped = 1'b1;
    case (paddr)
      `FSI_A_CTRL:   rd_w = {31'h0, quad_q};
      `FSI_A_STATUS: rd_w = {24'h0, status_w};
      `FSI_A_CONFIG: rd_w = {24'h0, cfg_q};
      `FSI_A_STATE:  rd_w = {29'h0, frame, dormant, busy};
      default: begin
        rd_w   = 32'h0;
        mapped = 1'b0;
      end
    endcase
  end

  // apb slave: one wait-free access phase, answer registered at the setup edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
      quad_q    <= 1'b0;
    end else begin
      pready_q  <= psel && !penable;
      pslverr_q <= psel && !penable && !mapped;
      if (psel && !penable) begin
        prdata_q <= rd_w;
      end
      if (psel && penable && pready_q && pwrite && paddr == `FSI_A_CTRL) begin
        quad_q <= pwdata[`FSI_CTRL_QUAD];  // lane mode; change only between frames
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
endmodule

// ==== fsi_flash_cmd_sva.sv ====
// concurrent checks on the decoder's register bus and serial pins
`timescale 1ns/1ps
`include "fsi_regs.svh"
module fsi_flash_cmd_sva (
  input logic        clock,
  input logic        rst_n,
  input logic        psel,
  input logic        penable,
  input logic [11:0] paddr,
  input logic        pready,
  input logic        pslverr,
  input logic        sck,
  input logic        cs_n,
  input logic [3:0]  io_out,
  input logic [3:0]  io_oe
);
  logic       sck_q;
  logic [7:0] age_q;
  logic [3:0] hi_q;
  // cycles since the last serial clock fall, saturating
  always_ff @(posedge clock) begin
    sck_q <= sck;
    if (!rst_n || (sck_q && !sck)) age_q <= 8'h00;
    else if (age_q != 8'hff) age_q <= age_q + 8'h01;
  end
  // cycles since select went high, saturating
  always_ff @(posedge clock) begin
    if (!rst_n || !cs_n) hi_q <= 4'h0;
    else if (hi_q != 4'hf) hi_q <= hi_q + 4'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_setup_answer;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_setup_answer: assert property (p_setup_answer) else $error("pready not one pulse after setup");
  property p_ready_cause;
    pready |-> psel && penable;
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("pready outside an access phase");
  property p_err_unmapped;
    psel && !penable && !(paddr inside {`FSI_A_CTRL, `FSI_A_STATUS, `FSI_A_CONFIG, `FSI_A_STATE}) |=> pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access without error");
  property p_ok_mapped;
    psel && !penable && (paddr inside {`FSI_A_CTRL, `FSI_A_STATUS, `FSI_A_CONFIG, `FSI_A_STATE}) |=> !pslverr;
  endproperty
  a_ok_mapped: assert property (p_ok_mapped) else $error("mapped access flagged as error");
  property p_oe_lanes;
    io_oe inside {4'h0, 4'h2, 4'hf};
  endproperty
  a_oe_lanes: assert property (p_oe_lanes) else $error("illegal output lane pattern");
  // a late change would land near the host's sampling rise
  property p_out_after_fall;
    (io_oe != 4'h0) && ($past(io_oe) != 4'h0) && $changed(io_out) |-> age_q <= 8'h07;
  endproperty
  a_out_after_fall: assert property (p_out_after_fall) else $error("output moved away from a fall");
  property p_idle_quiet;
    hi_q >= 4'h8 |-> io_oe == 4'h0;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("lines driven while deselected");
  property p_oe_release;
    $rose(cs_n) |-> ##[0:6] (io_oe == 4'h0);
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("lines not released after select");
endmodule
bind fsi_flash_cmd fsi_flash_cmd_sva u_sva (
  .clock   (clock),
  .rst_n   (rst_n),
  .psel    (psel),
  .penable (penable),
  .paddr   (paddr),
  .pready  (pready),
  .pslverr (pslverr),
  .sck     (sck),
  .cs_n    (cs_n),
  .io_out  (io_out),
  .io_oe   (io_oe)
);

// ==== fsi_host_model.sv ====
// serial host model: frames bytes out and collects reply bytes
`timescale 1ns/1ps
module fsi_host_model
  import fsi_pkg::*;
(
  output logic       sck,
  output logic       cs_n,
  output logic [3:0] io_in,
  input  logic [3:0] io_out,
  input  logic [3:0] io_oe
);
  logic      quad;
  logic      oe_seen;
  fsi_byte_t rx[$];
  // clock idles low, select high
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    io_in = 4'h0;
    quad = 1'b0;
    oe_seen = 1'b0;
  end
  // one byte msb first; data moves while the clock is low
  task automatic shift(input fsi_byte_t b, output fsi_byte_t r);
    int k;
    logic [3:0] line;
    r = 8'h00;
    for (k = 7; k >= 0; k = k - (quad ? 4 : 1)) begin
      io_in <= quad ? b[k-:4] : {~io_in[3:1], b[k]}; // idle lanes toggle
      #80;
      sck <= 1'b1;
      // an undriven lane shows the inverse of its last value, so a late enable is caught
      line = (io_out & io_oe) | (~io_out & ~io_oe);
      r = quad ? {r[3:0], line} : {r[6:0], line[1]};
      oe_seen = oe_seen | (|io_oe);
      #80;
      sck <= 1'b0;
    end
  endtask
  // select, bytes, dummies, replies, deselect; whole bytes only
  task automatic frame(input fsi_byte_t tx[$], input int nd, input int nrx);
    fsi_byte_t r;
    rx = {};
    oe_seen = 1'b0;
    cs_n <= 1'b0;
    foreach (tx[i]) shift(tx[i], r);
    repeat (nd) shift(8'h00, r);
    repeat (nrx) begin
      shift(8'h00, r);
      rx.push_back(r);
    end
    #80;
    cs_n <= 1'b1;
    io_in <= ~io_in; // released lines must not keep the last value
    #240;
  endtask
endmodule

// ==== fsi_flash_cmd_bench.sv ====
// bench: register bus and serial host traffic against the command decoder
`timescale 1ns/1ps
`include "fsi_regs.svh"
module fsi_flash_cmd_bench;
  import fsi_pkg::*;
  localparam fsi_byte_t DEV_ID = 8'h3b; // arbitrary
  localparam logic [127:0] FAC_ID = 128'h11223344556677889900aabbccddee5c; // arbitrary
  logic        clock;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  fsi_word_t   pwdata;
  fsi_word_t   prdata;
  logic        pready;
  logic        pslverr;
  logic        sck;
  logic        cs_n;
  logic [3:0]  io_in;
  logic [3:0]  io_out;
  logic [3:0]  io_oe;
  int          mismatches;
  int          comparisons;
  fsi_word_t   rd;
  logic        err;
  fsi_byte_t   fac;
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  fsi_flash_cmd #(.ID_PROG_CYC(400), .CONFIG_CYC(400), .FACTORY_ID(FAC_ID), .DEVICE_ID(DEV_ID)) dut (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe)
  );
  fsi_host_model host (.sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
  task automatic check(input string what, input fsi_word_t seen, input fsi_word_t exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input fsi_word_t d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input fsi_word_t m, input fsi_word_t exp);
    apb(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), rd & m, exp);
  endtask
  task automatic op1(input fsi_byte_t op);
    host.frame('{op}, 0, 0);
  endtask
  task automatic sstat(input fsi_byte_t exp);
    host.frame('{`FSI_OP_RD_STATUS}, host.quad ? 1 : 0, 1);
    check("serial status", 32'(host.rx[0]), 32'(exp));
  endtask
  task automatic idrd(input logic [15:0] a, input fsi_byte_t exp[$]);
    host.frame('{`FSI_OP_ID_READ, a[15:8], a[7:0]}, host.quad ? 3 : 1, exp.size());
    foreach (exp[i]) check("id byte", 32'(host.rx[i]), 32'(exp[i]));
  endtask
  task automatic prog(input logic [15:0] a, input fsi_byte_t d[$]);
    fsi_byte_t q[$];
    q = {`FSI_OP_ID_PROG, a[15:8], a[7:0], d};
    op1(`FSI_OP_WL_SET);
    host.frame(q, 0, 0);
  endtask
  // poll busy before the next command
  task automatic idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, `FSI_A_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 600);
    check("busy", 32'(rd[0]), 32'h0);
  endtask
  // cut a hang short
  initial begin
    #600000;
    mismatches++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mismatches = 0;
    comparisons = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    rdchk(`FSI_A_STATUS, 32'hff, 32'h0);
    rdchk(`FSI_A_CONFIG, 32'hff, 32'h0);
    apb(1'b1, 12'h010, 32'h1);
    check("unmapped", 32'(err), 32'h1);
    op1(`FSI_OP_WL_SET);
    sstat(8'h02);
    op1(`FSI_OP_WL_CLR);
    sstat(8'h00);
    host.frame('{`FSI_OP_WR_REGS, 8'h3c}, 0, 0);
    idle();
    sstat(8'h00);
    prog(16'h0010, '{8'h3c, 8'ha5});
    sstat(8'h01);
    idle();
    idrd(16'h0010, '{8'h3c, 8'ha5, 8'hff});
    prog(16'h01ff, '{8'h44, 8'h55});
    idle();
    idrd(16'h01ff, '{8'h44, 8'hff});
    idrd(16'h0100, '{8'h55});
    fac = FAC_ID[7:0];
    idrd(16'h000f, '{fac});
    prog(16'h000f, '{~fac});
    sstat(8'h00);
    idrd(16'h000f, '{fac});
    prog(16'h0800, '{8'h00});
    sstat(8'h00);
    apb(1'b1, `FSI_A_CTRL, 32'h1);
    host.quad = 1'b1;
    sstat(8'h00);
    idrd(16'h0010, '{8'h3c, 8'ha5});
    apb(1'b1, `FSI_A_CTRL, 32'h0);
    host.quad = 1'b0;
    op1(`FSI_OP_WL_SET);
    host.frame('{`FSI_OP_WR_REGS, 8'h3c, 8'h88}, 0, 0);
    idle();
    rdchk(`FSI_A_STATUS, 32'h7d, 32'h3c);
    rdchk(`FSI_A_CONFIG, 32'hff, 32'h80);
    op1(`FSI_OP_WL_SET);
    op1(`FSI_OP_LOCKDOWN);
    rdchk(`FSI_A_CONFIG, 32'hff, 32'h88);
    host.frame('{`FSI_OP_RD_CONFIG}, 0, 2);
    check("serial config", 32'({host.rx[0], host.rx[1]}), 32'h8888);
    op1(`FSI_OP_WL_SET);
    host.frame('{`FSI_OP_WR_REGS, 8'h00}, 0, 0);
    idle();
    rdchk(`FSI_A_STATUS, 32'h3c, 32'h3c);
    op1(`FSI_OP_WL_SET);
    op1(`FSI_OP_ID_LOCK);
    idle();
    rdchk(`FSI_A_STATUS, 32'h40, 32'h40);
    prog(16'h0020, '{8'h00});
    idle();
    idrd(16'h0020, '{8'hff});
    op1(`FSI_OP_SLEEP);
    repeat (380) @(posedge clock);
    rdchk(`FSI_A_STATE, 32'h2, 32'h2);
    host.frame('{`FSI_OP_RD_STATUS}, 0, 1);
    check("asleep drive", 32'(host.oe_seen), 32'h0);
    host.frame('{`FSI_OP_WAKE}, 3, 2);
    check("device id", 32'({host.rx[0], host.rx[1]}), 32'({DEV_ID, DEV_ID}));
    repeat (1260) @(posedge clock);
    sstat(8'h7c);
    conclude();
  end
endmodule
